// ### shared/ldum_params.svh
// What this block does
// - six-switch number picks the configuration entry
// - port-count switch picks four or eight drives
// - dual drive p serves logical p and p+4
// - dual only with four drives; else one each
// - four-drive entries may mix single and dual
// - each unit shows one of five emulated types
// - empty drive ports are allowed and left unmapped
// - only the active socket table is consulted
// - eight ports, four-port table, lsb off: next entry
// - lsb on: drives 4-7 repeat 0-3, single
//
// Purpose: constants of the logical drive unit mapper
// Assumes: byte addresses on the avalon-mm register port
// Notes:   types live in ldum_pkg
`ifndef LDUM_PARAMS_SVH
`define LDUM_PARAMS_SVH
// register byte offsets
`define LDUM_OFS_STATUS 8'h00
`define LDUM_OFS_QUERY  8'h04
`define LDUM_OFS_RESULT 8'h08
`define LDUM_OFS_PADDR  8'h0C
`define LDUM_OFS_PDATA  8'h10
// cycles to wait for the switch synchronisers after reset
`define LDUM_SETTLE_CYCLES 3
// table geometry
`define LDUM_LAST_PORT 3'h7
`define LDUM_ENTRY_STEP 6'h01
// unformatted capacities in megabytes
`define LDUM_CAP_SMALL_A 10'h050
`define LDUM_CAP_SMALL_B 10'h050
`define LDUM_CAP_LARGE   10'h12C
`define LDUM_CAP_MEDIUM  10'h0A0
`define LDUM_CAP_PACK    10'h0C8
`endif

// ### shared/ldum_pkg.sv
// Purpose: types shared by the mapper files
// Assumes: ldum_params.svh holds the numbers
// Notes:   all structs are packed
package ldum_pkg;
	// build sequencer states
	typedef enum logic [2:0] {
		LDUM_ST_SETTLE = 3'b000,
		LDUM_ST_LATCH  = 3'b001,
		LDUM_ST_FETCH  = 3'b010,
		LDUM_ST_APPLY  = 3'b011,
		LDUM_ST_DONE   = 3'b100
	} ldum_state_type;
	// emulated subsystem kinds
	typedef enum logic [2:0] {
		LDUM_EMU_SMALL_A = 3'b000,
		LDUM_EMU_SMALL_B = 3'b001,
		LDUM_EMU_LARGE   = 3'b010,
		LDUM_EMU_MEDIUM  = 3'b011,
		LDUM_EMU_PACK    = 3'b100
	} ldum_emul_type;
	// one table byte: a port slot of a configuration entry
	typedef struct packed {
		logic       used;
		logic       dual;
		logic [2:0] type_hi;
		logic [2:0] type_lo;
	} ldum_prom_word_type;
	// one logical unit of the map
	typedef struct packed {
		logic       valid;
		logic [2:0] port;
		logic       half;
		logic [2:0] emul;
	} ldum_unit_type;
	// switch and socket straps
	typedef struct packed {
		logic [5:0] cfg;
		logic       table8;
		logic       wide;
		logic       eight;
	} ldum_sw_type;
	// whole state of the top module
	typedef struct packed {
		ldum_sw_type             sync1;
		ldum_sw_type             sync2;
		ldum_sw_type             sw;
		ldum_state_type          st;
		logic [2:0]              cnt;
		logic [2:0]              port;
		ldum_unit_type [7:0]     map;
		logic [7:0]              drv_en;
		logic [7:0]              drv_dual;
		logic [2:0]              query;
		logic [31:0]             rdata;
		logic                    rvalid;
		logic [8:0]              paddr;
		ldum_unit_type           host;
		logic [9:0]              host_cap;
	} ldum_top_state_type;
endpackage

// ### hdl/ldum_cfg_rom.sv
// Purpose: storage of the active configuration socket
// Assumes: one write port, one registered read port
// Notes:   contents survive reset, like a fitted prom
module ldum_cfg_rom #(
	parameter int ADDR_W = 9,
	parameter int DATA_W = 8
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	// write side
	input  wire logic              we_in,
	input  wire logic [ADDR_W-1:0] waddr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	// read side
	input  wire logic [ADDR_W-1:0] raddr_in,
	output logic      [DATA_W-1:0] rdata_out
);
	logic [DATA_W-1:0] mem [2**ADDR_W];  // table bytes
	logic [DATA_W-1:0] rdata_r;          // registered read word

	// refuse shapes the addressing cannot serve
	if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : g_bad
		$error("ldum_cfg_rom: bad geometry");
	end

	// empty socket reads as unused slots
	initial begin
		for (int i = 0; i < 2**ADDR_W; i++) begin
			mem[i] = '0;
		end
	end

	// storage has no reset so a loaded table outlives it
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// read word comes out one cycle after the address
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= mem[raddr_in];
		end
	end

	assign rdata_out = rdata_r;
endmodule

// ### hdl/ldum_top.sv
// Purpose: maps logical disk units onto physical drive ports
// Assumes: switches are static pins, host lookup is on clk_in
// Notes:   mapping is rebuilt only at reset release
`include "ldum_params.svh"
module ldum_top #(
	parameter int SETTLE_CYCLES = `LDUM_SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// switch pins and socket strap
	input  wire logic [5:0]  config_number_in,
	input  wire logic        port_count_select_in,
	input  wire logic        wide_backplane_present_in,
	input  wire logic        prom_eight_port_in,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// host unit lookup
	input  wire logic [2:0]  host_unit_in,
	output logic             host_valid_out,
	output logic      [2:0]  host_port_out,
	output logic             host_upper_half_out,
	output logic      [2:0]  host_emul_out,
	output logic      [9:0]  host_capacity_out,
	// drive ports
	output logic      [7:0]  drive_enable_out,
	output logic      [7:0]  drive_dual_out,
	output logic             map_ready_out
);
	localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYCLES - 1);  // last settle count

	ldum_pkg::ldum_top_state_type s;        // registered state
	ldum_pkg::ldum_top_state_type n;        // next state
	ldum_pkg::ldum_sw_type        pins;     // raw switch levels
	ldum_pkg::ldum_prom_word_type word;     // table byte being applied
	ldum_pkg::ldum_unit_type      q;        // unit picked by query
	logic [8:0]                   rom_raddr;
	logic [7:0]                   rom_rdata;
	logic                         rom_we;
	logic                         ready;    // map built and frozen

	// the counter is three bits wide
	if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > 8) begin : g_bad
		$error("ldum_top: SETTLE_CYCLES out of range");
	end

	// table index of a port slot for the latched switches
	function automatic logic [8:0] prom_index(input ldum_pkg::ldum_sw_type sw, input logic [2:0] p);
		logic [5:0] entry;
		entry = sw.cfg;
		prom_index = {sw.cfg, p};
		// four-port table stretched over eight drives
		if (sw.eight && !sw.table8 && p[2]) begin
			if (!sw.cfg[0]) begin
				entry = 6'(sw.cfg + `LDUM_ENTRY_STEP);
			end
			prom_index = {entry, 1'b0, p[1:0]};
		end
	endfunction

	// ports 4-7 exist only with eight drives on a wide backplane
	function automatic logic port_live(input ldum_pkg::ldum_sw_type sw, input logic [2:0] p);
		port_live = !p[2] || (sw.eight && sw.wide);
	endfunction

	// capacity of an emulated kind, zero for an unknown code
	function automatic logic [9:0] emul_cap(input logic [2:0] e);
		case (e)
			ldum_pkg::LDUM_EMU_SMALL_A: emul_cap = `LDUM_CAP_SMALL_A;
			ldum_pkg::LDUM_EMU_SMALL_B: emul_cap = `LDUM_CAP_SMALL_B;
			ldum_pkg::LDUM_EMU_LARGE:   emul_cap = `LDUM_CAP_LARGE;
			ldum_pkg::LDUM_EMU_MEDIUM:  emul_cap = `LDUM_CAP_MEDIUM;
			ldum_pkg::LDUM_EMU_PACK:    emul_cap = `LDUM_CAP_PACK;
			default:                    emul_cap = 10'h000;
		endcase
	endfunction

	assign pins = '{cfg: config_number_in, table8: prom_eight_port_in,
		wide: wide_backplane_present_in, eight: port_count_select_in};
	assign ready = (s.st == ldum_pkg::LDUM_ST_DONE);
	assign word = ldum_pkg::ldum_prom_word_type'(rom_rdata);
	assign q = ready ? s.map[s.query] : '0;
	assign rom_raddr = prom_index(s.sw, s.port);

	// active socket; no other table source exists
	ldum_cfg_rom #(
		.ADDR_W (9),
		.DATA_W (8)
	) u_active_config_socket (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.we_in     (rom_we),
		.waddr_in  (s.paddr),
		.wdata_in  (avs_writedata_in[7:0]),
		.raddr_in  (rom_raddr),
		.rdata_out (rom_rdata)
	);

	// next-state logic: synchronisers, build sequencer, bus, host
	always_comb begin
		n = s;
		rom_we = 1'b0;
		n.sync1 = pins;
		n.sync2 = s.sync1;
		n.rvalid = 1'b0;
		case (s.st)
			// let the two-flop chains fill before trusting them
			ldum_pkg::LDUM_ST_SETTLE: begin
				n.cnt = 3'(s.cnt + 3'h1);
				if (s.cnt == SETTLE_LAST) begin
					n.st = ldum_pkg::LDUM_ST_LATCH;
				end
			end
			// switches taken once; later moves are ignored
			ldum_pkg::LDUM_ST_LATCH: begin
				n.sw = s.sync2;
				n.port = 3'h0;
				n.map = '0;
				n.drv_en = 8'h00;
				n.drv_dual = 8'h00;
				n.st = ldum_pkg::LDUM_ST_FETCH;
			end
			// address is on the table, data next cycle
			ldum_pkg::LDUM_ST_FETCH: begin
				n.st = ldum_pkg::LDUM_ST_APPLY;
			end
			// place this port's units into the map
			ldum_pkg::LDUM_ST_APPLY: begin
				if (port_live(s.sw, s.port) && word.used) begin
					n.map[s.port] = '{valid: 1'b1, port: s.port, half: 1'b0, emul: word.type_lo};
					n.drv_en[s.port] = 1'b1;
					// second unit only in the four-drive setting
					if (word.dual && !s.sw.eight) begin
						n.map[{1'b1, s.port[1:0]}] = '{valid: 1'b1, port: s.port, half: 1'b1,
							emul: word.type_hi};
						n.drv_dual[s.port] = 1'b1;
					end
				end
				if (s.port == `LDUM_LAST_PORT) begin
					n.st = ldum_pkg::LDUM_ST_DONE;
				end else begin
					n.port = 3'(s.port + 3'h1);
					n.st = ldum_pkg::LDUM_ST_FETCH;
				end
			end
			// frozen until the next reset
			ldum_pkg::LDUM_ST_DONE: begin
				n.st = ldum_pkg::LDUM_ST_DONE;
			end
			default: begin
				n.st = ldum_pkg::LDUM_ST_SETTLE;
			end
		endcase
		// read: one wait cycle, then the registered word
		if (avs_read_in && !s.rvalid) begin
			n.rvalid = 1'b1;
			case (avs_address_in)
				`LDUM_OFS_STATUS: n.rdata = {22'h0, s.sw.cfg, s.sw.table8, s.sw.wide, s.sw.eight, ready};
				`LDUM_OFS_QUERY:  n.rdata = {29'h0, s.query};
				`LDUM_OFS_RESULT: n.rdata = {14'h0, q.valid ? emul_cap(q.emul) : 10'h000,
					q.emul, q.half, q.port, q.valid};
				`LDUM_OFS_PADDR:  n.rdata = {23'h0, s.paddr};
				default:          n.rdata = 32'h0000_0000;
			endcase
		end
		// write: taken in the request cycle, low lane required
		if (avs_write_in && avs_byteenable_in[0]) begin
			case (avs_address_in)
				`LDUM_OFS_QUERY: n.query = avs_writedata_in[2:0];
				`LDUM_OFS_PADDR: n.paddr = avs_writedata_in[8:0];
				// byte load into the socket, pointer steps on
				`LDUM_OFS_PDATA: begin
					rom_we = 1'b1;
					n.paddr = 9'(s.paddr + 9'h001);
				end
				default: begin
				end
			endcase
		end
		// host lookup answers only from a finished map
		n.host = ready ? s.map[host_unit_in] : '0;
		n.host_cap = n.host.valid ? emul_cap(n.host.emul) : 10'h000;
	end

	// single state register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign avs_waitrequest_out = avs_read_in && !s.rvalid;
	assign avs_readdata_out = s.rdata;
	assign host_valid_out = s.host.valid;
	assign host_port_out = s.host.port;
	assign host_upper_half_out = s.host.half;
	assign host_emul_out = s.host.emul;
	assign host_capacity_out = s.host_cap;
	assign drive_enable_out = s.drv_en;
	assign drive_dual_out = s.drv_dual;
	assign map_ready_out = ready;

	// checks on the mapping
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	property p_entry_sel; (s.st == ldum_pkg::LDUM_ST_FETCH && !s.port[2])
		|-> rom_raddr == {s.sw.cfg, s.port}; endproperty
	a_entry_sel: assert property (p_entry_sel) else $error("entry not from switches");
	property p_four_ports; (ready && !s.sw.eight) |-> drive_enable_out[7:4] == 4'h0; endproperty
	a_four_ports: assert property (p_four_ports) else $error("upper port used with four drives");
	property p_dual_pair; host_valid_out && host_upper_half_out |->
		$past(host_unit_in[2]) && host_port_out == {1'b0, $past(host_unit_in[1:0])}; endproperty
	a_dual_pair: assert property (p_dual_pair) else $error("upper unit on wrong drive");
	property p_eight_single; s.sw.eight |-> drive_dual_out == 8'h00; endproperty
	a_eight_single: assert property (p_eight_single) else $error("dual drive with eight ports");
	property p_emul_known; host_valid_out |-> host_emul_out <= 3'h4 && host_capacity_out != 10'h000; endproperty
	a_emul_known: assert property (p_emul_known) else $error("unknown emulation");
	property p_empty_port; host_valid_out |-> drive_enable_out[host_port_out]; endproperty
	a_empty_port: assert property (p_empty_port) else $error("unit on empty port");
	property p_socket_only; (ready && rom_we) |=> $stable(s.map); endproperty
	a_socket_only: assert property (p_socket_only) else $error("socket load moved the map");
	property p_next_entry; (s.st == ldum_pkg::LDUM_ST_FETCH && s.sw.eight && !s.sw.table8 && s.port[2] && !s.sw.cfg[0])
		|-> rom_raddr[8:3] == 6'(s.sw.cfg + `LDUM_ENTRY_STEP); endproperty
	a_next_entry: assert property (p_next_entry) else $error("upper drives not from next entry");
	property p_repeat; (s.st == ldum_pkg::LDUM_ST_FETCH && s.sw.eight && !s.sw.table8 && s.port[2] && s.sw.cfg[0])
		|-> rom_raddr == {s.sw.cfg, 1'b0, s.port[1:0]}; endproperty
	a_repeat: assert property (p_repeat) else $error("upper drives do not repeat");
	property p_frozen; ready |=> ready && $stable(s.sw) && $stable(drive_enable_out); endproperty
	a_frozen: assert property (p_frozen) else $error("map changed after build");
	property p_build_time; $rose(s.st == ldum_pkg::LDUM_ST_LATCH) |-> ##[17:17] ready; endproperty
	a_build_time: assert property (p_build_time) else $error("build took wrong time");

	c_mix: cover property (ready && drive_dual_out != 8'h00 && (drive_enable_out & ~drive_dual_out) != 8'h00);
	c_repeat: cover property (ready && s.sw.eight && !s.sw.table8 && s.sw.cfg[0]);
	c_upper_hit: cover property (host_valid_out && host_upper_half_out);
endmodule

// ### test/ldum_drive_model.sv
// Purpose: drives cabled to the mapper's physical ports
// Assumes: each cabled drive answers to its own port number
// Notes:   an uncabled port never comes online
module ldum_drive_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// map outputs and cabling
	input  wire logic [7:0] drive_enable_in,
	input  wire logic [7:0] attach_in,
	// drive state
	output logic      [7:0] online_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// a drive comes online only when cabled and selected by the map
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			online_out <= 8'h00;
		end else begin
			online_out <= drive_enable_in & attach_in;
		end
	end
endmodule

// ### test/testbench.sv
// Purpose: self-checking bench of the logical drive unit mapper
// Assumes: default settle count, socket loaded over the register bus
// Notes:   the bench rebuilds the map from its own copy of the socket bytes
`include "ldum_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// design inputs
	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic [5:0]  cfg_sw = 6'h00;
	logic        eight_sw = 1'b0;
	logic        wide_sw = 1'b0;
	logic        tab8_sw = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [2:0]  unit = 3'h0;
	logic [7:0]  attach = 8'h00;
	// design outputs
	logic [31:0] rdata;
	logic        waitreq;
	logic        h_valid;
	logic        h_half;
	logic [2:0]  h_port;
	logic [2:0]  h_emul;
	logic [9:0]  h_cap;
	logic [7:0]  d_en;
	logic [7:0]  d_dual;
	logic        ready;
	logic [7:0]  online;
	// bench state: socket mirror, latched switch copies, counters
	logic [7:0]  mem [512];
	logic [31:0] rdq;
	logic [5:0]  cfg_q;
	logic        eight_q, wide_q, tab8_q;
	int          caps [5] = '{80, 80, 300, 160, 200};
	int          error_cnt = 0;
	int          comparisons = 0;

	ldum_top i_ldum_top (.clk_in(clk_in), .nrst_in(nrst_in), .config_number_in(cfg_sw),
		.port_count_select_in(eight_sw), .wide_backplane_present_in(wide_sw), .prom_eight_port_in(tab8_sw),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.host_unit_in(unit), .host_valid_out(h_valid), .host_port_out(h_port),
		.host_upper_half_out(h_half), .host_emul_out(h_emul), .host_capacity_out(h_cap),
		.drive_enable_out(d_en), .drive_dual_out(d_dual), .map_ready_out(ready));
	ldum_drive_model i_ldum_drive_model (.clk_in(clk_in), .nrst_in(nrst_in), .drive_enable_in(d_en),
		.attach_in(attach), .online_out(online));

	// free-running 100 MHz clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	// expected {capacity, emul, upper half, port, valid} of logical unit u
	function automatic logic [17:0] exp_unit(input int u);
		int p, s, e;
		logic [7:0] b;
		logic h, v;
		logic [2:0] t;
		h = !eight_q && u > 3;
		p = h ? u - 4 : u;
		e = cfg_q;
		s = eight_q ? u : u % 4;
		// four-port table stretched over eight ports
		if (eight_q && u > 3 && !tab8_q) begin
			s = u - 4;
			e = cfg_q[0] ? cfg_q : cfg_q + 1;
		end
		b = mem[e * 8 + s];
		t = h ? b[5:3] : b[2:0];
		v = b[7] && (h ? b[6] : 1'b1) && (!eight_q || u < 4 || wide_q);
		return v ? {10'(caps[t]), t, h, 3'(p), 1'b1} : 18'h0;
	endfunction

	// one avalon-mm transfer; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		be <= s;
		wr <= w;
		rd <= !w;
		do @(posedge clk_in); while (waitreq !== 1'b0);
		rdq = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// every unit through host lookup and the register pair, then drive ports
	task automatic check_map;
		logic [17:0] x;
		logic [7:0] en, du;
		en = 8'h00;
		du = 8'h00;
		for (int u = 0; u < 8; u++) begin
			x = exp_unit(u);
			if (x[0]) begin
				du[x[3:1]] = en[x[3:1]];
				en[x[3:1]] = 1'b1;
			end
			@(posedge clk_in);
			unit <= u[2:0];
			repeat (2) @(posedge clk_in);
			`CHK({h_cap, h_emul, h_half, h_port, h_valid}, x)
			bus(1'b1, `LDUM_OFS_QUERY, 32'(u), 4'hF);
			bus(1'b0, `LDUM_OFS_RESULT, 32'h0, 4'hF);
			`CHK(rdq, {14'h0, x})
		end
		`CHK(d_en, en)
		`CHK(d_dual, du)
		`CHK(online, en & attach)
	endtask

	// load two entries, set straps, reset, then check the frozen map
	task automatic run_round(input logic e8, input logic w, input logic t8, input logic [5:0] c);
		int n, k;
		logic [7:0] b;
		for (int i = 0; i < 16; i++) begin
			n = ((c + i / 8) % 64) * 8 + i % 8;
			b = {1'($urandom), 1'($urandom), 3'($urandom % 5), 3'($urandom % 5)};
			mem[n] = b;
			bus(1'b1, `LDUM_OFS_PADDR, 32'(n), 4'hF);
			bus(1'b1, `LDUM_OFS_PDATA, {24'h0, b}, 4'hF);
		end
		cfg_q = c;
		eight_q = e8;
		wide_q = w;
		tab8_q = t8;
		@(posedge clk_in);
		cfg_sw <= c;
		eight_sw <= e8;
		wide_sw <= w;
		tab8_sw <= t8;
		attach <= 8'($urandom);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		`CHK({ready, d_en}, 9'h000)
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		for (k = 0; k < 100 && ready !== 1'b1; k++) @(posedge clk_in);
		if (k == 100) error_cnt++;
		// switches moved after the build must not matter
		cfg_sw <= ~c;
		eight_sw <= ~e8;
		wide_sw <= ~w;
		tab8_sw <= ~t8;
		bus(1'b0, `LDUM_OFS_STATUS, 32'h0, 4'hF);
		`CHK(rdq, {22'h0, c, t8, w, e8, 1'b1})
		check_map();
	endtask

	// ends the run in one place
	task automatic final_report;
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// hang guard, well beyond the roughly 1600 cycles needed
	initial begin
		#500000;
		error_cnt++;
		final_report();
	end

	// main sequence: five strap modes, twice each
	initial begin
		logic [5:0] c;
		int m;
		void'($urandom(52));
		// socket writes during reset would all land on byte zero, so release first
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		for (int r = 0; r < 10; r++) begin
			m = r % 5;
			c = (r == 2) ? 6'h3E : 6'($urandom);
			if (m == 2) c[0] = 1'b0;
			if (m == 3) c[0] = 1'b1;
			run_round(m != 0, (m == 0) ? 1'($urandom) : (m != 4), (m == 1) || (m == 4 && 1'($urandom)), c);
		end
		// unmapped read, refused writes
		bus(1'b0, 8'h40, 32'h0, 4'hF);
		`CHK(rdq, 32'h0)
		bus(1'b1, `LDUM_OFS_QUERY, 32'h3, 4'hF);
		bus(1'b1, `LDUM_OFS_QUERY, 32'h5, 4'h0);
		bus(1'b0, `LDUM_OFS_QUERY, 32'h0, 4'hF);
		`CHK(rdq, 32'h3)
		bus(1'b1, `LDUM_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, `LDUM_OFS_STATUS, 32'h0, 4'hF);
		`CHK(rdq[0], 1'b1)
		final_report();
	end
endmodule
